// File: hw/pfd_motion_features.sv
// Pose, level and free-fall detection engines with their register slave.
// Assumes filtered samples from the same clock domain, one valid pulse each.
`timescale 1ns/10ps
`default_nettype none
// What this block does
// - High-asymmetric scheme: portrait below twice |x| minus hysteresis, landscape at twice |x| plus hysteresis.
// - Low-asymmetric scheme compares |y| against half |x|; codes up, down, left, right.
// - Symmetric scheme: portrait below |x| minus hyst, landscape at |x| plus hyst.
// - Two-bit scheme field: symmetric, high, low, symmetric.
// - Pose hysteresis step is 62.5 mg in any range.
// - Pose code top bit is the sign of z.
// - Pose flag rises on a pose change when enabled.
// - Pose flag clears after one unchanged evaluation.
// - Pose code tracks orientation whenever not blocked, regardless of flag enables; it holds its value while blocked.
// - Block selector 01 suppresses on tilt and high acceleration; 10 also on slope 0.2 g.
// - Selector 11 blocks on tilt, slope 0.4 g, or high g while unstable 100 ms.
// - Tilt blocking when tangent below root of parameter over eight, saturated values.
// - After a z sign change, react only once |z| exceeds 0.2 g.
// - Z-flip report enable decides whether top-bit changes raise the flag.
// - Level angle is arctangent of root of parameter over eight.
// - Level hysteresis shifts set and reset angles by the given terms.
// - Level bit reads one when flat, only while enabled.
// - Level flag after change stable for 0, 512, 1024 or 2048 ms.
// - Level flag: one sample when non-latched, else held until cleared.
// - Free-fall compares each magnitude or their sum with threshold.
// - Free-fall threshold step is 7.81 mg in any range.
// - Free-fall hysteresis step is 125 mg in any range.
// - Free-fall flag sets after (duration+1) samples of 2 ms below threshold.
// - Free-fall flag resets once above threshold plus hysteresis.
module pfd_motion_features
    import pfd_pkg::*;
(
    // Clock and reset
    input  wire logic             clk_i,
    input  wire logic             rst_i,
    // Filtered samples
    input  wire logic             sample_valid_i,
    input  wire pfd_acc_s         acc_i,
    // Wishbone slave
    input  wire logic             wb_cyc_i,
    input  wire logic             wb_stb_i,
    input  wire logic             wb_we_i,
    input  wire logic [ADR_W-1:0] wb_adr_i,
    input  wire logic [3:0]       wb_sel_i,
    input  wire logic [31:0]      wb_dat_i,
    output logic      [31:0]      wb_dat_o,
    output logic                  wb_ack_o,
    // Status toward the interrupt controller
    output logic      [2:0]       pose_code_o,
    output logic                  level_o,
    output logic                  pose_flag_o,
    output logic                  level_flag_o,
    output logic                  freefall_flag_o
);
    pfd_pose_cfg_s    pose_cfg;
    pfd_level_cfg_s   level_cfg;
    pfd_ff_cfg_s      ff_cfg;
    pfd_status_s      status;
    logic             level_clear;
    pfd_acc_s         prev_acc;
    logic [ACC_W-1:0] ax;
    logic [ACC_W-1:0] ay;
    logic [ACC_W-1:0] az;
    logic [ACC_W:0]   kx;
    logic signed [ACC_W-1:0] hyst;
    logic signed [SAT_W-1:0] sx;
    logic signed [SAT_W-1:0] sy;
    logic signed [SAT_W-1:0] sz;
    logic             portrait;
    logic             landscape;
    logic [1:0]       next_xy;
    logic             next_zbit;
    logic [2:0]       next_code;
    logic             tilt_blk;
    logic             high_acc;
    logic             slope_lo;
    logic             slope_hi;
    logic             unstable;
    logic             blocked;
    logic             pose_change;
    logic [6:0]       stable_cnt;
    logic [NUM_W-1:0] lvl_lo;
    logic [NUM_W-1:0] lvl_hi;
    logic             level_raw;
    logic             level_state;
    logic [10:0]      hold_cnt;
    logic [10:0]      hold_n;
    logic             level_event;
    logic             ff_flag;

    // Clamp a sample to the tilt range.
    function automatic logic signed [SAT_W-1:0] sat(input logic signed [ACC_W-1:0] a);
        if (a > SAT_MAX) begin
            return SAT_W'(SAT_MAX);
        end else if (a < -SAT_MAX) begin
            return SAT_W'(-SAT_MAX);
        end
        return SAT_W'(a);
    endfunction

    // True while 65536 * (x^2 + y^2) < num * z^2, num in 1/1024 units.
    function automatic logic tilt_lt(
        input logic signed [SAT_W-1:0] x,
        input logic signed [SAT_W-1:0] y,
        input logic signed [SAT_W-1:0] z,
        input logic [NUM_W-1:0] num
    );
        logic [TILT_W-1:0] lhs;
        logic [TILT_W-1:0] rhs;
        lhs = TILT_W'(x * x) + TILT_W'(y * y);
        lhs = lhs << TILT_SH;
        rhs = TILT_W'(num) * TILT_W'(z * z);
        return lhs < rhs;
    endfunction

    // True when one axis moved further than the limit since the last sample.
    function automatic logic slope_gt(
        input logic signed [ACC_W-1:0] a,
        input logic signed [ACC_W-1:0] b,
        input logic [ACC_W:0] lim
    );
        logic signed [ACC_W:0] d;
        d = (ACC_W+1)'(a) - (ACC_W+1)'(b);
        if (d[ACC_W]) begin
            d = -d;
        end
        return d > lim;
    endfunction

    pfd_wb_regs u_regs (
        .clk_i         (clk_i),
        .rst_i         (rst_i),
        .wb_cyc_i      (wb_cyc_i),
        .wb_stb_i      (wb_stb_i),
        .wb_we_i       (wb_we_i),
        .wb_adr_i      (wb_adr_i),
        .wb_sel_i      (wb_sel_i),
        .wb_dat_i      (wb_dat_i),
        .wb_dat_o      (wb_dat_o),
        .wb_ack_o      (wb_ack_o),
        .status_i      (status),
        .pose_cfg_o    (pose_cfg),
        .level_cfg_o   (level_cfg),
        .ff_cfg_o      (ff_cfg),
        .level_clear_o (level_clear)
    );

    pfd_freefall u_freefall (
        .clk_i          (clk_i),
        .rst_i          (rst_i),
        .sample_valid_i (sample_valid_i),
        .acc_i          (acc_i),
        .cfg_i          (ff_cfg),
        .flag_o         (ff_flag)
    );

    assign freefall_flag_o = ff_flag;

    always_comb begin
        status.blocked = blocked;
        status.ff_flag = ff_flag;
        status.level_flag = level_flag_o;
        status.pose_flag = pose_flag_o;
        status.level_state = level_o;
        status.pose_code = pose_code_o;
    end

    // Pose classification.
    always_comb begin
        ax = acc_abs(acc_i.x);
        ay = acc_abs(acc_i.y);
        az = acc_abs(acc_i.z);
        hyst = ACC_W'(pose_cfg.hyst) << POSE_HYST_SH;
        case (pose_cfg.scheme)
            SCH_HIGH: kx = {ax, 1'b0};
            SCH_LOW: kx = (ACC_W+1)'(ax >> 1);
            default: kx = (ACC_W+1)'(ax);
        endcase
        portrait = (ACC_W+1)'(ay) + (ACC_W+1)'(hyst) < (ACC_W+1)'(kx);
        landscape = (ACC_W+1)'(ay) >= (ACC_W+1)'(kx) + (ACC_W+1)'(hyst);
        next_xy = pose_code_o[1:0];
        if (portrait && acc_i.x >= hyst) begin
            next_xy = POSE_UP;
        end else if (portrait && acc_i.x < -hyst) begin
            next_xy = POSE_DOWN;
        end else if (landscape) begin
            next_xy = acc_i.y[ACC_W-1] ? POSE_LEFT : POSE_RIGHT;
        end
        next_zbit = pose_code_o[2];
        if (az > Z_HYST) begin
            next_zbit = acc_i.z[ACC_W-1];
        end
        next_code = {next_zbit, next_xy};
    end

    // Blocking conditions.
    always_comb begin
        sx = sat(acc_i.x);
        sy = sat(acc_i.y);
        sz = sat(acc_i.z);
        tilt_blk = tilt_lt(sx, sy, sz, NUM_W'(pose_cfg.block_theta) << ONE_SH);
        high_acc = ax > HIGH_ACC || ay > HIGH_ACC || az > HIGH_ACC;
        slope_lo = slope_gt(acc_i.x, prev_acc.x, SLOPE_LO) || slope_gt(acc_i.y, prev_acc.y, SLOPE_LO)
                   || slope_gt(acc_i.z, prev_acc.z, SLOPE_LO);
        slope_hi = slope_gt(acc_i.x, prev_acc.x, SLOPE_HI) || slope_gt(acc_i.y, prev_acc.y, SLOPE_HI)
                   || slope_gt(acc_i.z, prev_acc.z, SLOPE_HI);
        unstable = stable_cnt < 7'(POSE_STABLE_N);
        case (pose_cfg.block_sel)
            BLK_TILT: blocked = tilt_blk || high_acc;
            BLK_SLOPE_LO: blocked = tilt_blk || slope_lo || high_acc;
            BLK_SLOPE_HI: blocked = tilt_blk || slope_hi || (high_acc && unstable);
            default: blocked = 1'b0;
        endcase
        if (pose_cfg.zflip_report_enable) begin
            pose_change = !blocked && next_code != pose_code_o;
        end else begin
            pose_change = !blocked && next_code[1:0] != pose_code_o[1:0];
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            prev_acc <= '0;
        end else if (sample_valid_i) begin
            prev_acc <= acc_i;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pose_code_o <= '0;
            stable_cnt <= '0;
        end else if (sample_valid_i) begin
            if (!blocked && next_code != pose_code_o) begin
                pose_code_o <= next_code;
                stable_cnt <= '0;
            end else if (unstable) begin
                stable_cnt <= stable_cnt + 7'h01;
            end
        end
    end

    // Pose flag.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pose_flag_o <= 1'b0;
        end else if (sample_valid_i) begin
            pose_flag_o <= pose_cfg.pose_irq_en && pose_change;
        end
    end

    // Level thresholds.
    always_comb begin
        int lo;
        int hi;
        lo = 0;
        hi = 0;
        lo = int'(level_cfg.level_theta) * (LVL_DEN - int'(level_cfg.level_hysteresis))
             - (int'(level_cfg.level_hysteresis) << LVL_OFF_SH);
        hi = int'(level_cfg.level_theta) * (LVL_DEN + int'(level_cfg.level_hysteresis))
             + (int'(level_cfg.level_hysteresis) << LVL_OFF_SH);
        if (lo < 0) begin
            lo = 0;
        end
        lvl_lo = NUM_W'(lo);
        lvl_hi = NUM_W'(hi);
        case (level_cfg.hold_sel)
            2'h0: hold_n = '0;
            2'h1: hold_n = 11'(HOLD_BASE_N);
            2'h2: hold_n = 11'(HOLD_BASE_N) << 1;
            default: hold_n = 11'(HOLD_BASE_N) << 2;
        endcase
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_raw <= 1'b0;
        end else if (sample_valid_i) begin
            if (tilt_lt(sx, sy, sz, lvl_lo)) begin
                level_raw <= 1'b1;
            end else if (!tilt_lt(sx, sy, sz, lvl_hi)) begin
                level_raw <= 1'b0;
            end
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_state <= 1'b0;
            hold_cnt <= '0;
            level_event <= 1'b0;
        end else if (sample_valid_i) begin
            level_event <= 1'b0;
            if (level_raw == level_state) begin
                hold_cnt <= '0;
            end else if (hold_cnt + 11'h001 >= hold_n) begin
                level_state <= level_raw;
                hold_cnt <= '0;
                level_event <= level_cfg.level_en;
            end else begin
                hold_cnt <= hold_cnt + 11'h001;
            end
        end else begin
            level_event <= 1'b0;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_o <= 1'b0;
        end else begin
            level_o <= level_cfg.level_en && level_state;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            level_flag_o <= 1'b0;
        end else if (level_event) begin
            level_flag_o <= 1'b1;
        end else if (level_cfg.latch_mode ? level_clear : sample_valid_i) begin
            level_flag_o <= 1'b0;
        end
    end
endmodule
`default_nettype wire

// File: hw/pfd_pkg.sv
// Constants, carriers and shared helpers of the pose, level and free-fall engines.
// Assumes acceleration samples scaled at 1/1024 g per LSB.
package pfd_pkg;
    localparam int ACC_W = 14;
    localparam int SAT_W = 12;
    localparam int ADR_W = 12;
    localparam int NUM_W = 18;
    localparam int TILT_W = 44;
    localparam int TILT_SH = 16;
    localparam int ONE_SH = 10;
    localparam int LVL_DEN = 1024;
    localparam int LVL_OFF_SH = 6;
    localparam int POSE_HYST_SH = 6;
    localparam int FF_TH_SH = 3;
    localparam int FF_HY_SH = 7;
    localparam logic signed [ACC_W-1:0] SAT_MAX = 14'sh0400;
    localparam logic [ACC_W-1:0] Z_HYST = 14'h00CD;
    localparam logic [ACC_W:0] SLOPE_LO = 15'h00CD;
    localparam logic [ACC_W:0] SLOPE_HI = 15'h019A;
    localparam logic [ACC_W-1:0] HIGH_ACC = 14'h0600;
    localparam int SAMPLE_PERIOD_US = 2000;
    localparam int POSE_STABLE_MS = 100;
    localparam int HOLD_STEP_MS = 512;
    localparam int POSE_STABLE_N = POSE_STABLE_MS * 1000 / SAMPLE_PERIOD_US;
    localparam int HOLD_BASE_N = HOLD_STEP_MS * 1000 / SAMPLE_PERIOD_US;
    localparam logic [9:0] REG_FF_DUR = 10'h022;
    localparam logic [9:0] REG_FF_TH = 10'h023;
    localparam logic [9:0] REG_POSE_CFG = 10'h030;
    localparam logic [9:0] REG_LEVEL_CFG = 10'h031;
    localparam logic [9:0] REG_FF_CFG = 10'h032;
    localparam logic [9:0] REG_STATUS = 10'h033;
    localparam logic [9:0] REG_CLEAR = 10'h034;
    localparam logic [1:0] POSE_UP = 2'h0;
    localparam logic [1:0] POSE_DOWN = 2'h1;
    localparam logic [1:0] POSE_LEFT = 2'h2;
    localparam logic [1:0] POSE_RIGHT = 2'h3;

    typedef enum logic [1:0] {SCH_SYM, SCH_HIGH, SCH_LOW, SCH_SYM_ALT} pfd_scheme_e;
    typedef enum logic [1:0] {BLK_NONE, BLK_TILT, BLK_SLOPE_LO, BLK_SLOPE_HI} pfd_block_e;

    typedef struct packed {
        logic signed [ACC_W-1:0] x;
        logic signed [ACC_W-1:0] y;
        logic signed [ACC_W-1:0] z;
    } pfd_acc_s;
    typedef struct packed {
        logic       pose_irq_en;
        logic [5:0] block_theta;
        logic       zflip_report_enable;
        logic [2:0] hyst;
        pfd_block_e block_sel;
        pfd_scheme_e scheme;
    } pfd_pose_cfg_s;
    typedef struct packed {
        logic       latch_mode;
        logic       level_en;
        logic [1:0] hold_sel;
        logic [7:0] level_hysteresis;
        logic [5:0] level_theta;
    } pfd_level_cfg_s;
    typedef struct packed {
        logic [7:0] freefall_duration;
        logic [7:0] freefall_threshold;
        logic [1:0] freefall_hysteresis;
        logic       sum_select;
        logic       ff_en;
    } pfd_ff_cfg_s;
    typedef struct packed {
        logic       blocked;
        logic       ff_flag;
        logic       level_flag;
        logic       pose_flag;
        logic       level_state;
        logic [2:0] pose_code;
    } pfd_status_s;

    function automatic logic [ACC_W-1:0] acc_abs(input logic signed [ACC_W-1:0] a);
        return a[ACC_W-1] ? ACC_W'(-a) : ACC_W'(a);
    endfunction
endpackage

// File: hw/pfd_wb_regs.sv
// Wishbone classic register slave holding the engine configuration.
// Assumes a single-clock master; unmapped words read zero and ignore writes.
`timescale 1ns/10ps
`default_nettype none
module pfd_wb_regs
    import pfd_pkg::*;
(
    // Clock and reset
    input  wire logic              clk_i,
    input  wire logic              rst_i,
    // Wishbone slave
    input  wire logic              wb_cyc_i,
    input  wire logic              wb_stb_i,
    input  wire logic              wb_we_i,
    input  wire logic [ADR_W-1:0]  wb_adr_i,
    input  wire logic [3:0]        wb_sel_i,
    input  wire logic [31:0]       wb_dat_i,
    output logic      [31:0]       wb_dat_o,
    output logic                   wb_ack_o,
    // Engine side
    input  wire pfd_status_s       status_i,
    output pfd_pose_cfg_s          pose_cfg_o,
    output pfd_level_cfg_s         level_cfg_o,
    output pfd_ff_cfg_s            ff_cfg_o,
    output logic                   level_clear_o
);
    logic [9:0] idx;
    logic       wr;

    function automatic logic [31:0] merge(input logic [31:0] old, input logic [31:0] d, input logic [3:0] s);
        logic [31:0] r;
        r = old;
        for (int i = 0; i < 4; i++) begin
            if (s[i]) begin
                r[i*8 +: 8] = d[i*8 +: 8];
            end
        end
        return r;
    endfunction

    assign idx = wb_adr_i[ADR_W-1:2];
    assign wr = wb_cyc_i && wb_stb_i && wb_we_i && wb_ack_o;

    // Bus answer one cycle after the request.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= '0;
        end else begin
            wb_ack_o <= wb_cyc_i && wb_stb_i && !wb_ack_o;
            if (idx == REG_FF_DUR) begin
                wb_dat_o <= 32'(ff_cfg_o.freefall_duration);
            end else if (idx == REG_FF_TH) begin
                wb_dat_o <= 32'(ff_cfg_o.freefall_threshold);
            end else if (idx == REG_POSE_CFG) begin
                wb_dat_o <= 32'(pose_cfg_o);
            end else if (idx == REG_LEVEL_CFG) begin
                wb_dat_o <= 32'(level_cfg_o);
            end else if (idx == REG_FF_CFG) begin
                wb_dat_o <= 32'({ff_cfg_o.freefall_hysteresis, ff_cfg_o.sum_select, ff_cfg_o.ff_en});
            end else if (idx == REG_STATUS) begin
                wb_dat_o <= 32'(status_i);
            end else begin
                wb_dat_o <= '0;
            end
        end
    end

    // Configuration writes with byte lanes.
    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            pose_cfg_o <= '0;
            level_cfg_o <= '0;
            ff_cfg_o <= '0;
            level_clear_o <= 1'b0;
        end else begin
            level_clear_o <= wr && idx == REG_CLEAR && wb_sel_i[0] && wb_dat_i[0];
            if (wr && idx == REG_FF_DUR) begin
                ff_cfg_o.freefall_duration <= 8'(merge(32'(ff_cfg_o.freefall_duration), wb_dat_i, wb_sel_i));
            end
            if (wr && idx == REG_FF_TH) begin
                ff_cfg_o.freefall_threshold <= 8'(merge(32'(ff_cfg_o.freefall_threshold), wb_dat_i, wb_sel_i));
            end
            if (wr && idx == REG_POSE_CFG) begin
                pose_cfg_o <= pfd_pose_cfg_s'(15'(merge(32'(pose_cfg_o), wb_dat_i, wb_sel_i)));
            end
            if (wr && idx == REG_LEVEL_CFG) begin
                level_cfg_o <= pfd_level_cfg_s'(18'(merge(32'(level_cfg_o), wb_dat_i, wb_sel_i)));
            end
            if (wr && idx == REG_FF_CFG && wb_sel_i[0]) begin
                {ff_cfg_o.freefall_hysteresis, ff_cfg_o.sum_select, ff_cfg_o.ff_en} <= wb_dat_i[3:0];
            end
        end
    end
endmodule
`default_nettype wire

// File: hw/pfd_freefall.sv
// Free-fall engine: single or sum comparison with duration and hysteresis.
// Assumes one sample_valid_i pulse per new filtered sample.
`timescale 1ns/10ps
`default_nettype none
module pfd_freefall
    import pfd_pkg::*;
(
    // Clock and reset
    input  wire logic        clk_i,
    input  wire logic        rst_i,
    // Samples and setup
    input  wire logic        sample_valid_i,
    input  wire pfd_acc_s    acc_i,
    input  wire pfd_ff_cfg_s cfg_i,
    // Result
    output logic             flag_o
);
    logic [ACC_W-1:0] ax, ay, az;
    logic [ACC_W+1:0] sum, th, th_hy;
    logic             below, above;
    logic [8:0]       cnt;

    always_comb begin
        ax = acc_abs(acc_i.x);
        ay = acc_abs(acc_i.y);
        az = acc_abs(acc_i.z);
        sum = (ACC_W+2)'(ax) + (ACC_W+2)'(ay) + (ACC_W+2)'(az);
        th = (ACC_W+2)'(cfg_i.freefall_threshold) << FF_TH_SH;
        th_hy = th + ((ACC_W+2)'(cfg_i.freefall_hysteresis) << FF_HY_SH);
        if (cfg_i.sum_select) begin
            below = sum < th;
            above = sum > th_hy;
        end else begin
            below = ax < th && ay < th && az < th;
            above = ax > th_hy || ay > th_hy || az > th_hy;
        end
    end

    always_ff @(posedge clk_i) begin
        if (rst_i) begin
            cnt <= '0;
            flag_o <= 1'b0;
        end else if (!cfg_i.ff_en) begin
            cnt <= '0;
            flag_o <= 1'b0;
        end else if (sample_valid_i) begin
            if (below) begin
                if (cnt <= 9'(cfg_i.freefall_duration)) begin
                    cnt <= cnt + 9'h001;
                end
                if (cnt == 9'(cfg_i.freefall_duration)) begin
                    flag_o <= 1'b1;
                end
            end else begin
                cnt <= '0;
            end
            if (above) begin
                flag_o <= 1'b0;
            end
        end
    end
endmodule
`default_nettype wire

// File: testbench/pfd_motion_asserts.sv
// Port checks for the motion feature block.
// Assumes it is bound onto the top module.
`timescale 1ns/10ps
`default_nettype none
module pfd_motion_asserts
    import pfd_pkg::*;
(
    // Watched ports
    input wire logic       clk_i,
    input wire logic       rst_i,
    input wire logic       sample_valid_i,
    input wire pfd_acc_s   acc_i,
    input wire logic       wb_cyc_i,
    input wire logic       wb_stb_i,
    input wire logic       wb_ack_o,
    input wire logic [2:0] pose_code_o,
    input wire logic       pose_flag_o,
    input wire logic       freefall_flag_o
);
    default clocking @(posedge clk_i); endclocking
    default disable iff (rst_i);
    sequence s_req;
        wb_cyc_i && wb_stb_i && !wb_ack_o;
    endsequence
    sequence s_same;
        sample_valid_i ##1 $stable(pose_code_o);
    endsequence
    chk_ack_next: assert property (s_req |=> wb_ack_o) else $error("ack late");
    chk_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o) else $error("ack long");
    chk_ack_cause: assert property ($rose(wb_ack_o) |-> $past(wb_cyc_i) && $past(wb_stb_i)) else $error("ack unasked");
    chk_code_idle: assert property (!sample_valid_i |=> $stable(pose_code_o)) else $error("code moved");
    chk_z_sign: assert property (sample_valid_i && acc_i.z < -14'sh00CD ##1 $changed(pose_code_o)
        |-> pose_code_o[2]) else $error("z bit wrong");
    chk_flag_rise: assert property ($rose(pose_flag_o) |-> $changed(pose_code_o)) else $error("flag no change");
    chk_flag_clear: assert property (s_same |-> !pose_flag_o) else $error("flag stuck");
    chk_ff_idle: assert property (!sample_valid_i |=> $stable(freefall_flag_o)) else $error("ff moved");
endmodule
`default_nettype wire

// File: testbench/pfd_host_model.sv
// Host model: Wishbone classic master for single transfers.
// Assumes a slave that acks each request once.
`timescale 1ns/10ps
`default_nettype none
module pfd_host_model
    import pfd_pkg::*;
(
    // Bus master side
    input  wire logic        clk_i,
    input  wire logic        ack_i,
    input  wire logic [31:0] dat_i,
    output logic             cyc_o = 1'b0,
    output logic             stb_o = 1'b0,
    output logic             we_o = 1'b0,
    output logic [ADR_W-1:0] adr_o = '0,
    output logic [3:0]       sel_o = 4'hF,
    output logic [31:0]      dat_o = '0
);
    task automatic xfer(input logic w, input logic [9:0] i, input logic [31:0] d, output logic [31:0] r);
        cyc_o <= 1'b1;
        stb_o <= 1'b1;
        we_o <= w;
        adr_o <= {i, 2'h0};
        dat_o <= d;
        @(posedge clk_i);
        while (ack_i !== 1'b1) @(posedge clk_i);
        r = dat_i;
        cyc_o <= 1'b0;
        stb_o <= 1'b0;
        @(posedge clk_i);
    endtask
endmodule
`default_nettype wire

// File: testbench/tb.sv
// Self-checking bench for the pose, level and free-fall engines.
// Assumes the host model as bus master.
`timescale 1ns/10ps
`default_nettype none
module tb
    import pfd_pkg::*;
;
    typedef struct packed {logic [1:0] s; pfd_acc_s a; logic [2:0] c;} pfd_row_s;
    logic             clk_i = 1'b0;
    logic             rst_i = 1'b1;
    logic             sample_valid_i = 1'b0;
    pfd_acc_s         acc_i = '0;
    logic             wb_cyc_i, wb_stb_i, wb_we_i, wb_ack_o;
    logic [ADR_W-1:0] wb_adr_i;
    logic [3:0]       wb_sel_i;
    logic [31:0]      wb_dat_i, wb_dat_o, rd;
    logic [2:0]       pose_code_o;
    logic             level_o, pose_flag_o, level_flag_o, freefall_flag_o;
    int               miscompares = 0;
    int               check_count = 0;
    int               cycles = 0;
    pfd_row_s         rows [6] = '{'{2'h0, '{14'h0064, 14'h0384, -14'h012C}, 3'h7},
        '{2'h0, '{-14'h03E8, 14'h0064, 14'h012C}, 3'h1}, '{2'h0, '{14'h0000, -14'h0384, -14'h012C}, 3'h6},
        '{2'h1, '{14'h01F4, -14'h0384, 14'h012C}, 3'h0}, '{2'h2, '{14'h03E8, 14'h0258, 14'h012C}, 3'h3},
        '{2'h3, '{14'h03E8, 14'h0258, 14'h012C}, 3'h0}};
    always #50 clk_i = ~clk_i;
    pfd_motion_features dut (.*);
    pfd_host_model host (.clk_i(clk_i), .ack_i(wb_ack_o), .dat_i(wb_dat_o), .cyc_o(wb_cyc_i),
        .stb_o(wb_stb_i), .we_o(wb_we_i), .adr_o(wb_adr_i), .sel_o(wb_sel_i), .dat_o(wb_dat_i));
    task automatic chk(input string n, input logic [31:0] e, input logic [31:0] g);
        check_count++;
        if (g !== e) begin
            miscompares++;
            $display("[ERR] %s expected %h seen %h", n, e, g);
        end
    endtask
    task automatic smp(input pfd_acc_s a);
        sample_valid_i <= 1'b1;
        acc_i <= a;
        @(posedge clk_i);
        sample_valid_i <= 1'b0;
        repeat (2) @(posedge clk_i);
    endtask
    task automatic report_and_stop();
        if (miscompares == 0 && check_count > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask
    always @(posedge clk_i) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            miscompares++;
            report_and_stop();
        end
    end
    initial begin
        repeat (16) @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        host.xfer(1'b0, REG_POSE_CFG, '0, rd);
        chk("pose_cfg", 0, rd);
        for (int i = 0; i < 6; i++) begin
            host.xfer(1'b1, REG_POSE_CFG, 32'h4080 | 32'(rows[i].s), rd);
            smp(rows[i].a);
            chk("pose_code", rows[i].c, pose_code_o);
            chk("pose_flag", 1, pose_flag_o);
        end
        smp(rows[5].a);
        chk("pose_flag", 0, pose_flag_o);
        host.xfer(1'b1, REG_POSE_CFG, 32'h4000, rd);
        smp('{14'h03E8, 14'h0258, -14'h012C});
        chk("pose_code", 4, pose_code_o);
        chk("pose_flag", 0, pose_flag_o);
        host.xfer(1'b1, REG_POSE_CFG, 32'h0080, rd);
        smp('{14'h0000, 14'h0384, 14'h0064});
        chk("pose_code", 7, pose_code_o);
        chk("pose_flag", 0, pose_flag_o);
        host.xfer(1'b1, REG_FF_TH, 32'h0A, rd);
        host.xfer(1'b1, REG_FF_DUR, 32'h02, rd);
        host.xfer(1'b1, REG_FF_CFG, 32'h05, rd);
        host.xfer(1'b0, REG_FF_TH, '0, rd);
        chk("ff_th", 32'h0A, rd);
        host.xfer(1'b0, 10'h3F0, '0, rd);
        chk("unmapped", 0, rd);
        repeat (2) smp('0);
        chk("ff_flag", 0, freefall_flag_o);
        smp('0);
        chk("ff_flag", 1, freefall_flag_o);
        smp('{14'h0000, 14'h0000, 14'h00D0});
        chk("ff_flag", 1, freefall_flag_o);
        smp('{14'h0000, 14'h0000, 14'h00D1});
        chk("ff_flag", 0, freefall_flag_o);
        host.xfer(1'b1, REG_POSE_CFG, 32'h0804, rd);
        smp('{14'h0000, -14'h0064, -14'h0400});
        chk("pose_code", 3, pose_code_o);
        smp('{14'h0000, -14'h0640, 14'h0000});
        chk("pose_code", 3, pose_code_o);
        host.xfer(1'b1, REG_POSE_CFG, 32'h080C, rd);
        smp('{14'h0000, -14'h03E8, 14'h0000});
        chk("pose_code", 3, pose_code_o);
        smp('{14'h0000, -14'h03E8, 14'h0000});
        chk("pose_code", 2, pose_code_o);
        host.xfer(1'b1, REG_LEVEL_CFG, 32'h10008, rd);
        repeat (2) smp('{14'h0000, 14'h0000, 14'h0400});
        chk("level", 1, level_o);
        chk("level_flag", 1, level_flag_o);
        smp('{14'h0000, 14'h0000, 14'h0400});
        chk("level_flag", 0, level_flag_o);
        rst_i <= 1'b1;
        @(posedge clk_i);
        rst_i <= 1'b0;
        @(posedge clk_i);
        chk("rst_code", 0, pose_code_o);
        report_and_stop();
    end
endmodule
bind pfd_motion_features pfd_motion_asserts chk (.*);
`default_nettype wire
